//--- verilog/pwrite_pkg.sv
// Purpose: shared constants and carriers for the parallel write port block
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   depth defaults follow the larger documented capacity
`default_nettype none
package pwrite_pkg;
  localparam int WORD_W        = 9;
  localparam int DEPTH         = 4096;
  localparam int STAGE_DEPTH   = 32;
  localparam logic RST_EMPTY_N = 1'b0;
  localparam logic RST_BOUND_N = 1'b0;
  localparam logic RST_HALF_N  = 1'b1;
  localparam logic RST_FULL_N  = 1'b1;

  typedef struct packed {
    logic empty_n;
    logic bound_n;
    logic half_n;
    logic full_n;
  } flags_t;

  typedef enum logic [1:0] {
    WR_IDLE   = 2'b00,
    WR_ACTIVE = 2'b01,
    WR_REFUSE = 2'b10
  } wr_state_t;
endpackage
`default_nettype wire

//--- verilog/stage_fifo.sv
// Purpose: small valid/ready staging FIFO on the serial word path
// Assumes: single clock, synchronous active-low reset
// Notes:   width and depth are parameters; depth must be a power of two
`default_nettype none
module stage_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign in_ready  = (wp - rp) != (AW+1)'(DEPTH);
  assign out_valid = wp != rp;
  assign out_data  = mem[rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verilog/fifo_parallel_write_port_flags.sv
// Purpose: parallel write side of a parallel-to-serial FIFO with status flags
// Assumes: write strobe and serial shift clock are sampled synchronous inputs
// Notes:   strobe and shift clock edges are detected on clk; flags are registered
//
// Behaviour
// - all nine data bits are captured together as one stored word
// - falling write strobe starts a write only when not full
// - strobe falling while full stores nothing and keeps the pointer
// - accepted word goes to storage at the write pointer
// - write pointer advances on the rising strobe ending an accepted write
// - writes and serial reads run independently without pointer corruption
// - empty flag goes high after the rising strobe of a write
// - half and boundary flags update from the falling strobe crossing thresholds
// - master clear drives empty and boundary flags low
// - master clear drives half and full flags high
// - empty flag drops at the shift edge starting bit zero of last word
// - a shift edge freeing a place in a full buffer raises full flag
// - boundary flag low less than one eighth from empty or from full
// - half flag low when count with any reserved place exceeds half the capacity
// - no word is read while the empty flag is low
`default_nettype none
module fifo_parallel_write_port_flags
  import pwrite_pkg::*;
#(
  parameter int WIDTH       = WORD_W,
  parameter int CAPACITY    = DEPTH,
  parameter int STAGE_WORDS = STAGE_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             master_clear_n,
  input  wire logic [WIDTH-1:0] parallel_in_word,
  input  wire logic             write_strobe_n,
  input  wire logic             serial_shift_clock,
  input  wire logic [3:0]       word_bits,
  output logic                  serial_out,
  output logic                  serial_out_en,
  output logic                  empty_indicator_n,
  output logic                  boundary_fill_indicator_n,
  output logic                  half_level_indicator_n,
  output logic                  full_indicator_n
);
  localparam int AW = $clog2(CAPACITY);
  localparam logic [AW:0] CAP_CNT  = (AW+1)'(CAPACITY);
  localparam logic [AW:0] HALF_CNT = (AW+1)'(CAPACITY / 2);
  localparam logic [AW:0] LOW_CNT  = (AW+1)'(CAPACITY / 8);
  localparam logic [AW:0] HIGH_CNT = (AW+1)'(CAPACITY - CAPACITY / 8);

  logic [WIDTH-1:0] ram [CAPACITY];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             strobe_q;
  logic             shift_q;
  logic             strobe_fall;
  logic             strobe_rise;
  logic             shift_rise;
  logic             clear;
  wr_state_t        wr_state;
  logic [WIDTH-1:0] held_word;
  logic [WIDTH-1:0] shreg;
  logic [3:0]       bit_idx;
  logic             shifting;
  logic             fetch;
  logic             stage_in_ready;
  logic [WIDTH-1:0] stage_data;
  logic             stage_valid;
  logic             stage_take;
  logic             accept_fall;
  logic             commit;
  logic             reserve;
  flags_t           level_flags;
  flags_t           stored_flags;
  flags_t           flags;

  // occupancy from wrapped pointers, correct across wrap
  function automatic logic [AW:0] fill_of(input logic [AW:0] w, input logic [AW:0] r);
    fill_of = w - r;
  endfunction

  // flag set for a given fill count
  function automatic flags_t flags_of(input logic [AW:0] n);
    flags_of.empty_n = (n != '0);
    // exactly one eighth and exactly seven eighths still count as mid range
    flags_of.bound_n = !((n < LOW_CNT) || (n > HIGH_CNT));
    flags_of.half_n  = !(n > HALF_CNT);
    flags_of.full_n  = (n != CAP_CNT);
  endfunction

  assign clear       = !rst_n || !master_clear_n;
  assign strobe_fall = strobe_q && !write_strobe_n;
  assign strobe_rise = !strobe_q && write_strobe_n;
  assign shift_rise  = !shift_q && serial_shift_clock;
  // a new word is fetched at the shift edge starting its bit zero, never from empty;
  // the edge that ends a word also starts the next, so no shift edge is lost
  assign fetch       = shift_rise && (!shifting || bit_idx == word_bits - 1'b1)
                       && flags.empty_n && stage_in_ready;
  assign stage_take  = stage_valid && (!shifting || (shift_rise && bit_idx == word_bits - 1'b1));

  // write side events; an accepted fall reserves one place until its rise stores the word
  assign accept_fall = strobe_fall && wr_state == WR_IDLE && flags.full_n;
  assign commit      = wr_state == WR_ACTIVE && strobe_rise;
  assign reserve     = accept_fall || wr_state == WR_ACTIVE;

  // occupancy the next edge leaves behind: level counts the reserved place, stored does not,
  // so a read in the same cycle as any write edge is never lost from the flags
  assign level_flags  = flags_of(fill_of(wr_ptr + {{AW{1'b0}}, reserve}, rd_ptr + {{AW{1'b0}}, fetch}));
  assign stored_flags = flags_of(fill_of(wr_ptr + {{AW{1'b0}}, commit}, rd_ptr + {{AW{1'b0}}, fetch}));

  // edge history of the strobes
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      strobe_q <= 1'b1;
      shift_q  <= 1'b0;
    end
    else
    begin
      strobe_q <= write_strobe_n;
      shift_q  <= serial_shift_clock;
    end
  end

  // write cycle control: accept or refuse on the falling strobe
  always_ff @(posedge clk)
  begin
    if (clear)
      wr_state <= WR_IDLE;
    else
    begin
      unique case (wr_state)
        WR_IDLE:
        begin
          if (strobe_fall)
            wr_state <= flags.full_n ? WR_ACTIVE : WR_REFUSE;
        end
        WR_ACTIVE, WR_REFUSE:
        begin
          if (strobe_rise)
            wr_state <= WR_IDLE;
        end
        default:
          wr_state <= WR_IDLE;
      endcase
    end
  end

  // word is latched while the strobe is low so the rising edge sees setup data
  always_ff @(posedge clk)
  begin
    if (wr_state == WR_ACTIVE && !write_strobe_n)
      held_word <= parallel_in_word;
  end

  // storage write at the current write pointer
  always_ff @(posedge clk)
  begin
    if (wr_state == WR_ACTIVE && strobe_rise)
      ram[wr_ptr[AW-1:0]] <= held_word;
  end

  // write pointer, owned only by the write side
  always_ff @(posedge clk)
  begin
    if (clear)
      wr_ptr <= '0;
    else if (wr_state == WR_ACTIVE && strobe_rise)
      wr_ptr <= wr_ptr + 1'b1;
  end

  // read pointer, owned only by the read side
  always_ff @(posedge clk)
  begin
    if (clear)
      rd_ptr <= '0;
    else if (fetch)
      rd_ptr <= rd_ptr + 1'b1;
  end

  // feed fetched words into the staging buffer; it stalls fetches when full
  stage_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (STAGE_WORDS)
  ) u_stage (
    .clk       (clk),
    .rst_n     (!clear),
    .in_data   (ram[rd_ptr[AW-1:0]]),
    .in_valid  (fetch),
    .in_ready  (stage_in_ready),
    .out_data  (stage_data),
    .out_valid (stage_valid),
    .out_ready (stage_take)
  );

  // serial shifter, least significant bit first
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      shreg    <= '0;
      bit_idx  <= '0;
      shifting <= 1'b0;
    end
    else if (stage_take)
    begin
      shreg    <= stage_data;
      bit_idx  <= '0;
      shifting <= 1'b1;
    end
    else if (shifting && shift_rise)
    begin
      shreg   <= shreg >> 1;
      bit_idx <= bit_idx + 1'b1;
      if (bit_idx == word_bits - 1'b1)
        shifting <= 1'b0;
    end
  end

  // serial output pins, registered; enable only while a word is shifting
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else
    begin
      serial_out    <= shreg[0];
      serial_out_en <= shifting;
    end
  end

  // flag update; full, half and boundary count writes from the falling strobe so full is seen early,
  // which costs the refused-write check nothing since it uses the same flag
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      flags.empty_n <= RST_EMPTY_N;
      flags.bound_n <= RST_BOUND_N;
      flags.half_n  <= RST_HALF_N;
      flags.full_n  <= RST_FULL_N;
    end
    else
    begin
      flags.full_n  <= level_flags.full_n;
      flags.half_n  <= level_flags.half_n;
      flags.bound_n <= level_flags.bound_n;
      flags.empty_n <= stored_flags.empty_n;
    end
  end

  // flags leave through flip-flops
  assign empty_indicator_n         = flags.empty_n;
  assign boundary_fill_indicator_n = flags.bound_n;
  assign half_level_indicator_n    = flags.half_n;
  assign full_indicator_n          = flags.full_n;
endmodule
`default_nettype wire

//--- tb/pwrite_checker.sv
// Purpose: port checks on the write flags block
// Assumes: one clock, rst_n synchronous
// Notes:   occupancy figures are judged by the bench
`default_nettype none
module pwrite_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_clear_n,
  input wire logic write_strobe_n,
  input wire logic serial_shift_clock,
  input wire logic empty_indicator_n,
  input wire logic boundary_fill_indicator_n,
  input wire logic half_level_indicator_n,
  input wire logic full_indicator_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // short aliases keep each relation on one line
  wire logic emp  = empty_indicator_n;
  wire logic bnd  = boundary_fill_indicator_n;
  wire logic half = half_level_indicator_n;
  wire logic full = full_indicator_n;
  wire logic wr   = write_strobe_n;
  wire logic shc  = serial_shift_clock;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // flags are registered, so edge relations allow the one-edge lag
  property p_clr_low; !master_clear_n |=> !emp && !bnd; endproperty
  a_clr_low: assert property (p_clr_low) else $error("clear low pair");
  property p_clr_high; !master_clear_n |=> half && full; endproperty
  a_clr_high: assert property (p_clr_high) else $error("clear high pair");
  property p_empty_bnd; !emp |-> !bnd; endproperty
  a_empty_bnd: assert property (p_empty_bnd) else $error("boundary while empty");
  property p_full_lvl; !full |-> !half && !bnd; endproperty
  a_full_lvl: assert property (p_full_lvl) else $error("levels while full");
  property p_refuse; $fell(wr) && !full && !shc && !$past(shc) |=> !full; endproperty
  a_refuse: assert property (p_refuse) else $error("refused write freed");
  property p_full_fall; $fell(full) |-> !$past(wr); endproperty
  a_full_fall: assert property (p_full_fall) else $error("full without strobe");
  property p_empty_rise; $rose(emp) |-> $past(wr) && !$past(wr, 3); endproperty
  a_empty_rise: assert property (p_empty_rise) else $error("empty rose early");
  property p_full_rise; $rose(full) && $past(rst_n) && $past(master_clear_n) |-> $past(shc) || $past(shc, 2); endproperty
  a_full_rise: assert property (p_full_rise) else $error("full rose without read");
  // empty drops only one edge after a detected shift clock rise, clears aside
  property p_empty_fall; $fell(emp) && $past(master_clear_n) |-> $past(shc); endproperty
  a_empty_fall: assert property (p_empty_fall) else $error("empty fell without read");
  // level flags move only after a low strobe sample or a shift clock rise
  property p_level_move; ($changed(half) || $changed(bnd)) && $past(master_clear_n) |-> !$past(wr) || $past(shc); endproperty
  a_level_move: assert property (p_level_move) else $error("level flag moved idle");
endmodule
bind fifo_parallel_write_port_flags pwrite_checker u_chk (.clk, .rst_n, .master_clear_n, .write_strobe_n,
  .serial_shift_clock, .empty_indicator_n, .boundary_fill_indicator_n, .half_level_indicator_n, .full_indicator_n);
`default_nettype wire

//--- tb/host_model.sv
// Purpose: writer and shift clock source facing the block
// Assumes: drives 1 ns after each clk rise
// Notes:   data inverted between strobes so a stale word never looks valid
`default_nettype none
module host_model
  import pwrite_pkg::*;
(
  input  wire logic              clk,
  output logic                   write_strobe_n,
  output logic      [WORD_W-1:0] parallel_in_word,
  output logic                   serial_shift_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    write_strobe_n = 1'b1;
    parallel_in_word = '0;
    serial_shift_clock = 1'b0;
  end
  // word held from the fall through the sampled rise
  task automatic write_word(input logic [WORD_W-1:0] w, input int lo, input int hi);
    @(posedge clk) #1;
    parallel_in_word = w;
    write_strobe_n = 1'b0;
    repeat (lo) @(posedge clk);
    #1 write_strobe_n = 1'b1;
    @(posedge clk) #1 parallel_in_word = ~w;
    repeat (hi - 2) @(posedge clk);
  endtask
  // shift clock stands low between words
  task automatic shift_word(input int n);
    repeat (n)
    begin
      @(posedge clk) #1 serial_shift_clock = 1'b1;
      repeat (6) @(posedge clk);
      #1 serial_shift_clock = 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/fifo_parallel_write_port_flags_tb.sv
// Purpose: self-checking bench for the write flags block
// Assumes: capacity shrunk to 16 so every threshold is reached
// Notes:   serial words are matched in order against a write queue
`default_nettype none
module fifo_parallel_write_port_flags_tb
  import pwrite_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CAP = 16;
  logic              clk = 1'b0;
  logic              rst_n, master_clear_n, write_strobe_n, serial_shift_clock, serial_out, serial_out_en;
  logic              empty_indicator_n, boundary_fill_indicator_n, half_level_indicator_n, full_indicator_n;
  logic        [3:0] word_bits = 4'h9;
  logic [WORD_W-1:0] parallel_in_word, word, exp_q[$];
  int                seed, cnt, i, nbits, cycles, n_mismatch, tests_run;
  flags_t            fl;
  always #5 clk = ~clk;
  fifo_parallel_write_port_flags #(.CAPACITY(CAP)) u_dut (.clk, .rst_n, .master_clear_n, .parallel_in_word,
    .write_strobe_n, .serial_shift_clock, .word_bits, .serial_out, .serial_out_en, .empty_indicator_n,
    .boundary_fill_indicator_n, .half_level_indicator_n, .full_indicator_n);
  host_model u_host (.clk, .write_strobe_n, .parallel_in_word, .serial_shift_clock);
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected flags follow the stored count alone
  task automatic flags_ok();
    repeat (3) @(posedge clk);
    fl = '{cnt != 0, cnt >= CAP / 8 && cnt <= CAP - CAP / 8, cnt <= CAP / 2, cnt != CAP};
    check({5'h0, empty_indicator_n, boundary_fill_indicator_n, half_level_indicator_n, full_indicator_n},
          {5'h0, fl});
  endtask
  task automatic put(input int lo, input int hi);
    logic [WORD_W-1:0] w;
    w = WORD_W'($random(seed));
    exp_q.push_back(w);
    u_host.write_word(w, lo, hi);
    cnt++;
  endtask
  task automatic take();
    u_host.shift_word(WORD_W);
    cnt--;
  endtask
  // one bit per falling shift edge while a word is out, lowest bit first
  always @(negedge serial_shift_clock)
    if (serial_out_en === 1'b1)
    begin
      word[nbits] = serial_out;
      nbits++;
      if (nbits == WORD_W)
      begin
        nbits = 0;
        check(word, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      end
    end
  // a hung handshake ends the run instead of stalling it
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    seed = 32'h994D;
    rst_n = 1'b0;
    master_clear_n = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    flags_ok();
    // fill to the brim with mixed strobe lengths, then one write too many
    for (i = 0; i < CAP; i++)
    begin
      put(2 + i % 3, 2 + i % 2);
      flags_ok();
    end
    u_host.write_word(9'h0AA, 2, 2);
    flags_ok();
    for (i = 0; i < CAP; i++)
    begin
      take();
      flags_ok();
    end
    // back-to-back writes while words are being read
    fork
      for (int k = 0; k < 6; k++)
        put(2, 2);
      begin
        repeat (12) @(posedge clk);
        repeat (6) take();
      end
    join
    flags_ok();
    put(5, 4);
    put(3, 2);
    @(posedge clk) #1 master_clear_n = 1'b0;
    @(posedge clk) #1 master_clear_n = 1'b1;
    exp_q.delete();
    cnt = 0;
    flags_ok();
    put(2, 2);
    take();
    check(WORD_W'(exp_q.size()), '0);
    test_done();
  end
endmodule
`default_nettype wire
